// [bridge_ctrl_defines.svh]
// Purpose: Constants for the half-bridge control word decoder
// Assumes: 16-bit frames, MSB first
// Notes:   Included by the package and the decoder
`ifndef BRIDGE_CTRL_DEFINES_SVH
`define BRIDGE_CTRL_DEFINES_SVH
`define FRAME_BITS        16
`define BIT_CLEAR_REQ     15
`define BIT_BANK_SEL      14
`define BIT_OL_SHUTDOWN   13
`define BANK0_ACT_MSB     12
`define BANK1_ACT_MSB     10
`define ACT_LSB           7
`define BANK0_POL_MSB     6
`define BANK1_POL_MSB     4
`define POL_LSB           1
`define BANK0_BRIDGES     6
`define BANK1_BRIDGES     4
`define NUM_BRIDGES       10
`define CTRL_RESET        16'h0000
`define STATUS_BANK_RESET 1'b0
`endif

// [bridge_ctrl_pkg.sv]
// Purpose: Types for the half-bridge control word decoder
// Assumes: Constants come from bridge_ctrl_defines.svh
// Notes:   Types only
`include "bridge_ctrl_defines.svh"
package bridge_ctrl_pkg;
	typedef struct packed {
		logic [`NUM_BRIDGES-1:0] bridge_activate;
		logic [`NUM_BRIDGES-1:0] bridge_polarity;
	} bridge_drive_t;
	typedef struct packed {
		logic [`NUM_BRIDGES-1:0] high_side_switch;
		logic [`NUM_BRIDGES-1:0] low_side_switch;
	} switch_cmd_t;
	typedef enum logic [0:0] {
		BANK_LOW  = 1'b0,
		BANK_HIGH = 1'b1
	} bank_t;
endpackage

// [half_bridge_control_word_decoder.sv]
// Purpose: Serial control word receiver and decoder for ten half-bridges
// Assumes: Serial clock far slower than i_clock; sampled, not a clock
// Notes:   Diagnosis word content comes in on i_status_bank*
`timescale 1ns/1ps
`include "bridge_ctrl_defines.svh"

// How it works
// RQ1 - Bit 14 picks bank low or high
// RQ2 - Bit 15 clears addressed bank's errors
// RQ3 - Clear acts only on addressed bank
// RQ4 - Bit 13 enables open-load shutdown
// RQ5 - Shutdown enable per bank only
// RQ6 - Bank 0 bits 12..7 activate bridges 6..1
// RQ7 - Bank 1 bits 10..7 activate 10..7
// RQ8 - Bank 0 bits 6..1 set polarity
// RQ9 - Bank 1 bits 4..1 set polarity
// RQ10 - Master sends bit 0 as zero
// RQ11 - Apply on select rise, hold until next
// RQ12 - Sixteen bits MSB first, clock low
// RQ13 - Addressed bank's status returned next frame
// RQ14 - Reset clears both banks to zero
module half_bridge_control_word_decoder
	import bridge_ctrl_pkg::*;
(
	// Clock and reset
	input  wire logic                    i_clock,
	input  wire logic                    i_reset,
	// Serial link pins
	input  wire logic                    i_serial_clock,
	input  wire logic                    i_chip_select_n,
	input  wire logic                    i_serial_in,
	output logic                         o_serial_out,
	output logic                         o_serial_out_oe_n,
	// Diagnosis words of the two banks
	input  wire logic [`FRAME_BITS-1:0]  i_status_bank0,
	input  wire logic [`FRAME_BITS-1:0]  i_status_bank1,
	// Bridge drive
	output bridge_drive_t                o_drive,
	output switch_cmd_t                  o_switch,
	output logic [1:0]                   o_open_load_shutdown_enable,
	output logic [1:0]                   o_status_clear,
	output logic [`FRAME_BITS-1:0]       o_last_word
);

	// Three-stage synchronisers; only stages 2 and 3 are looked at
	logic [2:0] sclk_sync;
	logic [2:0] cs_sync;
	logic [2:0] sdi_sync;

	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			sclk_sync <= 3'h0;
			cs_sync   <= 3'h7;
			sdi_sync  <= 3'h0;
		end else begin
			sclk_sync <= {sclk_sync[1:0], i_serial_clock};
			cs_sync   <= {cs_sync[1:0], i_chip_select_n};
			sdi_sync  <= {sdi_sync[1:0], i_serial_in};
		end
	end

	// Filtered levels change once stages 2 and 3 agree
	logic sclk_lvl;
	logic cs_lvl;
	logic sdi_lvl;

	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			sclk_lvl <= 1'b0;
			cs_lvl   <= 1'b1;
			sdi_lvl  <= 1'b0;
		end else begin
			if (sclk_sync[1] == sclk_sync[2])
				sclk_lvl <= sclk_sync[2];
			if (cs_sync[1] == cs_sync[2])
				cs_lvl <= cs_sync[2];
			if (sdi_sync[1] == sdi_sync[2])
				sdi_lvl <= sdi_sync[2];
		end
	end

	logic next_sclk_lvl;
	logic next_cs_lvl;
	assign next_sclk_lvl = (sclk_sync[1] == sclk_sync[2]) ?
		sclk_sync[2] : sclk_lvl;
	assign next_cs_lvl = (cs_sync[1] == cs_sync[2]) ? cs_sync[2] : cs_lvl;

	logic sclk_rise;
	logic cs_fall;
	logic cs_rise;
	assign sclk_rise = next_sclk_lvl & ~sclk_lvl;
	assign cs_fall   = ~next_cs_lvl & cs_lvl;
	assign cs_rise   = next_cs_lvl & ~cs_lvl;

	// Receive shift register, MSB first, sampled on serial clock rise
	logic [`FRAME_BITS-1:0] rx_shift;
	logic [4:0]             bit_count;

	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			rx_shift  <= 16'h0000;
			bit_count <= 5'h00;
		end else if (cs_fall) begin
			bit_count <= 5'h00;
		end else if (!cs_lvl && sclk_rise) begin
			rx_shift <= {rx_shift[`FRAME_BITS-2:0], sdi_lvl}; // [RQ12]
			if (bit_count != 5'h1F)
				bit_count <= bit_count + 5'h01;
		end
	end

	// Short or long frames are dropped so a torn word never lands
	logic frame_ok;
	assign frame_ok = (bit_count == 5'(`FRAME_BITS)); // [RQ12]

	logic [`FRAME_BITS-1:0] bank0_word;
	logic [`FRAME_BITS-1:0] bank1_word;
	bank_t                  status_bank;

	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			bank0_word <= `CTRL_RESET; // [RQ14]
			bank1_word <= `CTRL_RESET; // [RQ14]
		end else if (cs_rise && frame_ok) begin
			if (rx_shift[`BIT_BANK_SEL] == BANK_HIGH) // [RQ1]
				bank1_word <= rx_shift; // [RQ11]
			else
				bank0_word <= rx_shift; // [RQ11]
		end
	end

	// Address of the status word sent in the following frame
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset)
			status_bank <= bank_t'(`STATUS_BANK_RESET); // [RQ13]
		else if (cs_rise && frame_ok)
			status_bank <= bank_t'(rx_shift[`BIT_BANK_SEL]); // [RQ13]
	end

	// One-cycle clear pulse to the error latches of one bank only
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset)
			o_status_clear <= 2'h0;
		else if (cs_rise && frame_ok && rx_shift[`BIT_CLEAR_REQ]) begin
			o_status_clear[0] <= ~rx_shift[`BIT_BANK_SEL]; // [RQ2] [RQ3]
			o_status_clear[1] <= rx_shift[`BIT_BANK_SEL];  // [RQ2] [RQ3]
		end else
			o_status_clear <= 2'h0;
	end

	// Decoded drive from the stored words
	bridge_drive_t next_drive;
	always_comb begin
		next_drive = '0;
		for (int i = 0; i < `BANK0_BRIDGES; i++) begin
			next_drive.bridge_activate[i] =
				bank0_word[`ACT_LSB + i]; // [RQ6]
			next_drive.bridge_polarity[i] =
				bank0_word[`POL_LSB + i]; // [RQ8]
		end
		for (int i = 0; i < `BANK1_BRIDGES; i++) begin
			next_drive.bridge_activate[`BANK0_BRIDGES + i] =
				bank1_word[`ACT_LSB + i]; // [RQ7]
			next_drive.bridge_polarity[`BANK0_BRIDGES + i] =
				bank1_word[`POL_LSB + i]; // [RQ9]
		end
	end

	switch_cmd_t next_switch;
	always_comb begin
		next_switch.high_side_switch =
			next_drive.bridge_activate & next_drive.bridge_polarity;
		next_switch.low_side_switch =
			next_drive.bridge_activate & ~next_drive.bridge_polarity;
	end

	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			o_drive                     <= '0;
			o_switch                    <= '0;
			o_open_load_shutdown_enable <= 2'h0;
			o_last_word                 <= 16'h0000;
		end else begin
			o_drive  <= next_drive;
			o_switch <= next_switch;
			o_open_load_shutdown_enable <= {bank1_word[`BIT_OL_SHUTDOWN],
				bank0_word[`BIT_OL_SHUTDOWN]}; // [RQ4] [RQ5]
			if (cs_rise && frame_ok)
				o_last_word <= rx_shift;
		end
	end

	// Status shift-out: loaded at select fall, shifted on clock rise
	logic [`FRAME_BITS-1:0] tx_shift;
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			tx_shift <= 16'h0000;
		end else if (cs_fall) begin
			tx_shift <= (status_bank == BANK_HIGH) ?
				i_status_bank1 : i_status_bank0; // [RQ13]
		end else if (!cs_lvl && sclk_rise) begin
			tx_shift <= {tx_shift[`FRAME_BITS-2:0], 1'b0};
		end
	end

	// Master samples before rising edge; data changes after rising edge
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			o_serial_out      <= 1'b0;
			o_serial_out_oe_n <= 1'b1;
		end else begin
			o_serial_out_oe_n <= next_cs_lvl;
			if (cs_fall)
				o_serial_out <= (status_bank == BANK_HIGH) ?
					i_status_bank1[`FRAME_BITS-1] :
					i_status_bank0[`FRAME_BITS-1];
			else if (!cs_lvl && sclk_rise)
				o_serial_out <= tx_shift[`FRAME_BITS-2];
		end
	end

	// Checks
	property p_clear_bank;
		@(posedge i_clock) disable iff (i_reset)
		(cs_rise && frame_ok && rx_shift[`BIT_CLEAR_REQ]) |=>
		(o_status_clear == (rx_shift[`BIT_BANK_SEL] ? 2'h2 : 2'h1));
	endproperty
	a_clear_bank: assert property (p_clear_bank) // [RQ2] [RQ3]
		else $error("status clear went to wrong bank");

	property p_no_clear;
		@(posedge i_clock) disable iff (i_reset)
		!(cs_rise && frame_ok && rx_shift[`BIT_CLEAR_REQ]) |=>
		(o_status_clear == 2'h0);
	endproperty
	a_no_clear: assert property (p_no_clear) // [RQ2]
		else $error("status clear without request");

	sequence s_bank0_write;
		cs_rise && frame_ok && !rx_shift[`BIT_BANK_SEL];
	endsequence
	property p_bank0_act;
		logic [`FRAME_BITS-1:0] w;
		@(posedge i_clock) disable iff (i_reset)
		(s_bank0_write, w = rx_shift) ##2 1 |->
		o_drive.bridge_activate[5:0] == w[12:7] &&
		o_drive.bridge_polarity[5:0] == w[6:1];
	endproperty
	a_bank0_act: assert property (p_bank0_act) // [RQ6] [RQ8] [RQ11]
		else $error("bank low decode wrong");

	property p_bank1_act;
		logic [`FRAME_BITS-1:0] w;
		@(posedge i_clock) disable iff (i_reset)
		(cs_rise && frame_ok && rx_shift[`BIT_BANK_SEL], w = rx_shift)
		##2 1 |->
		o_drive.bridge_activate[9:6] == w[10:7] &&
		o_drive.bridge_polarity[9:6] == w[4:1] &&
		o_open_load_shutdown_enable[1] == w[13];
	endproperty
	a_bank1_act: assert property (p_bank1_act) // [RQ1] [RQ7] [RQ9] [RQ5]
		else $error("bank high decode wrong");

	property p_hold;
		@(posedge i_clock) disable iff (i_reset)
		!cs_rise |=> $stable(bank0_word) && $stable(bank1_word);
	endproperty
	a_hold: assert property (p_hold) // [RQ11]
		else $error("control word changed outside select rise");

	// An active bridge has exactly one switch on, a parked one none
	property p_switch_excl;
		@(posedge i_clock) disable iff (i_reset)
		((o_switch.high_side_switch & o_switch.low_side_switch) == '0) &&
		((o_switch.high_side_switch | o_switch.low_side_switch) ==
		o_drive.bridge_activate);
	endproperty
	a_switch_excl: assert property (p_switch_excl) // [RQ8]
		else $error("both switches on in one bridge");

	property p_ol_bank0;
		@(posedge i_clock) disable iff (i_reset)
		s_bank0_write ##2 1 |->
		o_open_load_shutdown_enable[0] == $past(rx_shift[13], 2);
	endproperty
	a_ol_bank0: assert property (p_ol_bank0) // [RQ4] [RQ5]
		else $error("open-load enable not applied");

	property p_tristate;
		@(posedge i_clock) disable iff (i_reset)
		cs_lvl && $past(cs_lvl) |-> o_serial_out_oe_n;
	endproperty
	a_tristate: assert property (p_tristate) // [RQ13]
		else $error("serial out driven while deselected");

	// The first status bit must stand before the master's first sample
	property p_first_status_bit;
		logic s;
		@(posedge i_clock) disable iff (i_reset)
		(cs_fall, s = (status_bank == BANK_HIGH) ?
			i_status_bank1[`FRAME_BITS-1] : i_status_bank0[`FRAME_BITS-1])
		|=> !o_serial_out_oe_n && o_serial_out == s;
	endproperty
	a_first_status_bit: assert property (p_first_status_bit) // [RQ13]
		else $error("first status bit not driven at select fall");

	property p_drop_torn;
		@(posedge i_clock) disable iff (i_reset)
		(cs_rise && !frame_ok) |=>
		$stable(status_bank) && $stable(o_last_word) &&
		(o_status_clear == 2'h0);
	endproperty
	a_drop_torn: assert property (p_drop_torn) // [RQ12]
		else $error("torn frame changed state");

endmodule // half_bridge_control_word_decoder

// [spi_master_model.sv]
// Purpose: Serial master that sends control words and reads status
// Assumes: Link clock 80 ns, stands low outside frames
// Notes:   Samples status before each rise, as the device shifts after it
`timescale 1ns/1ps
module spi_master_model (
	// Clock and status pin
	input  wire logic i_clock,
	input  wire logic i_serial_out,
	// Link pins
	output logic      o_serial_clock,
	output logic      o_chip_select_n,
	output logic      o_serial_in
);
	initial begin
		o_serial_clock = 1'b0;
		o_chip_select_n = 1'b1;
		o_serial_in = 1'b0;
	end
	task automatic frame(input logic [15:0] w, input int n,
		output logic [15:0] rx);
		rx = 16'h0000;
		@(posedge i_clock) o_chip_select_n <= 1'b0;
		for (int i = 0; i < n; i++) begin
			// Bit 0 always goes out low, whatever the caller passed
			o_serial_in <= (i == 15) ? 1'b0 : w[15-i];
			repeat (9) @(posedge i_clock);
			@(negedge i_clock) rx = {rx[14:0], i_serial_out};
			@(posedge i_clock) o_serial_clock <= 1'b1;
			repeat (10) @(posedge i_clock);
			o_serial_clock <= 1'b0;
		end
		repeat (10) @(posedge i_clock);
		o_chip_select_n <= 1'b1;
		// A released line must not keep its last value
		o_serial_in <= ~o_serial_in;
		repeat (12) @(posedge i_clock);
	endtask
endmodule // spi_master_model

// [test_half_bridge_control_word_decoder.sv]
// Purpose: Self-checking bench for the control word decoder
// Assumes: Status words held constant; master model drives the link
// Notes:   Expected drive state is rebuilt from the accepted words
`timescale 1ns/1ps
module test_half_bridge_control_word_decoder
	import bridge_ctrl_pkg::*;
;
	logic          i_clock, i_reset, sclk, cs_n, sdi, sdo, oe_n;
	logic [15:0]   st0, st1, last_word, w0, w1, last;
	bridge_drive_t drive;
	switch_cmd_t   sw;
	logic [1:0]    ol, clr, clr_seen;
	int            errors, checked;
	half_bridge_control_word_decoder half_bridge_control_word_decoder_inst (
		.i_clock(i_clock), .i_reset(i_reset), .i_serial_clock(sclk),
		.i_chip_select_n(cs_n), .i_serial_in(sdi), .o_serial_out(sdo),
		.o_serial_out_oe_n(oe_n), .i_status_bank0(st0),
		.i_status_bank1(st1), .o_drive(drive), .o_switch(sw),
		.o_open_load_shutdown_enable(ol), .o_status_clear(clr),
		.o_last_word(last_word));
	spi_master_model spi_master_model_inst (
		.i_clock(i_clock), .i_serial_out(sdo), .o_serial_clock(sclk),
		.o_chip_select_n(cs_n), .o_serial_in(sdi));
	initial begin
		i_clock = 1'b0;
		forever #2 i_clock = ~i_clock;
	end
	// Clear is a one-cycle pulse, so collect it
	always @(posedge i_clock) clr_seen <= clr_seen | clr;
	task automatic cmp_out(input logic [44:0] got, input logic [44:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic [41:0] expect_outs(logic [15:0] a,
		logic [15:0] b);
		logic [9:0] act, pol;
		act = {b[10:7], a[12:7]};
		pol = {b[4:1], a[6:1]};
		return {act, pol, act & pol, act & ~pol, b[13], a[13]};
	endfunction
	task automatic apply(input logic [15:0] w, input int n,
		input logic [15:0] exp_rx);
		logic [15:0] rx;
		logic [1:0]  c;
		c = 2'b00;
		// Off the edge, so the collector cannot undo the clear
		@(negedge i_clock) clr_seen = 2'b00;
		spi_master_model_inst.frame(w, n, rx);
		if (n == 16) begin
			c = {w[15] & w[14], w[15] & ~w[14]};
			if (w[14]) w1 = w;
			else w0 = w;
			last = w;
			cmp_word(rx, exp_rx);
		end
		cmp_out({drive, sw, ol, oe_n, clr_seen},
			{expect_outs(w0, w1), 1'b1, c});
		cmp_word(last_word, last);
		$display("frame %h of %0d bits done", w, n);
	endtask
	task automatic t_reset;
		@(posedge i_clock) i_reset <= 1'b1;
		repeat (3) @(posedge i_clock);
		i_reset <= 1'b0;
		w0 = 16'h0000;
		w1 = 16'h0000;
		last = 16'h0000;
		@(negedge i_clock);
		cmp_out({drive, sw, ol, oe_n, clr}, {42'h0, 1'b1, 2'b00});
		repeat (4) @(posedge i_clock);
		$display("reset test done");
	endtask
	task automatic t_bank_low;
		apply(16'hB954, 16, 16'hA5C3);
	endtask
	task automatic t_bank_high;
		apply(16'hDE7E, 16, 16'hA5C3);
	endtask
	task automatic t_short_frame;
		apply(16'hA9FE, 8, 16'h0000);
		apply(16'h1F80, 16, 16'h3C5A);
	endtask
	task automatic t_after_reset;
		t_reset;
		apply(16'h4786, 16, 16'hA5C3);
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		errors = 0;
		checked = 0;
		clr_seen = 2'b00;
		i_reset = 1'b1;
		st0 = 16'hA5C3;
		st1 = 16'h3C5A;
		t_reset;
		t_bank_low;
		t_bank_high;
		t_short_frame;
		t_after_reset;
		tally_and_finish;
	end
	initial begin
		#100000;
		errors++;
		tally_and_finish;
	end
endmodule // test_half_bridge_control_word_decoder
